//--- src/tcr_clamp.sv
// signed saturation of a 16-bit word into an inclusive range
`timescale 1ns/1ps
module tcr_clamp (
   // value and limits
   input  wire logic signed [15:0] val_i,
   input  wire logic signed [15:0] lo_i,
   input  wire logic signed [15:0] hi_i,
   // limited value
   output logic signed      [15:0] val_o
);

   // above range takes the upper limit, below takes the lower
   always_comb begin
      if (val_i > hi_i) begin
         val_o = hi_i;
      end else if (val_i < lo_i) begin
         val_o = lo_i;
      end else begin
         val_o = val_i;
      end
   end

endmodule : tcr_clamp

//--- src/tcr_pkg.sv
// constants, types and register map of the register bank
package tcr_pkg;

   // register word addresses
   localparam logic [15:0] ADDR_INT_PROBE  = 16'h0040;
   localparam logic [15:0] ADDR_EXT_PROBE  = 16'h0041;
   localparam logic [15:0] ADDR_MEAN       = 16'h0042;
   localparam logic [15:0] ADDR_CONDITION  = 16'h0043;
   localparam logic [15:0] ADDR_FAULT_A    = 16'h0044;
   localparam logic [15:0] ADDR_FAULT_B    = 16'h0045;
   localparam logic [15:0] ADDR_DRIVE_PCT  = 16'h0046;
   localparam logic [15:0] ADDR_OP_SELECT  = 16'h0050;
   localparam logic [15:0] ADDR_SETPOINT   = 16'h0051;
   localparam logic [15:0] ADDR_OFFSET     = 16'h0052;
   localparam logic [15:0] ADDR_PROP_BAND  = 16'h0053;
   localparam logic [15:0] ADDR_SPARE      = 16'h0054;
   localparam logic [15:0] ADDR_INT_TIME   = 16'h0055;
   localparam logic [15:0] ADDR_DER_TIME   = 16'h0056;
   localparam logic [15:0] ADDR_HEAT_CAP   = 16'h0057;
   localparam logic [15:0] ADDR_COOL_CAP   = 16'h0058;

   // unit_condition bit positions
   localparam int COND_RUN_BIT   = 0;
   localparam int COND_ALARM_BIT = 1;
   localparam int COND_WARN_BIT  = 2;

   // fault_word_a bit positions
   localparam int FA_SYS_ONE_BIT   = 1;
   localparam int FA_SYS_TWO_BIT   = 2;
   localparam int FA_BACKUP_BIT    = 3;
   localparam int FA_DC_SUPPLY_BIT = 11;
   localparam int FA_OVERTEMP_BIT  = 12;
   localparam int FA_UNDERTEMP_BIT = 13;
   localparam int FA_THERMO_BIT    = 14;
   localparam int FA_DRIVE_BIT     = 15;

   // fault_word_b bit positions
   localparam int FB_LOW_FLOW_BIT  = 0;
   localparam int FB_INNER_OPEN_BIT = 1;
   localparam int FB_OUTER_OPEN_BIT = 2;
   localparam int FB_AUTOTUNE_BIT  = 3;
   localparam int FB_LOW_LEVEL_BIT = 4;
   localparam int FB_WARN_HI_BIT   = 12;
   localparam int FB_WARN_LO_BIT   = 13;

   // ranges, signed, 0.01 degC / 1 s / 1 % per lsb
   localparam logic signed [15:0] PROBE_MIN = 16'shfc22;
   localparam logic signed [15:0] PROBE_MAX = 16'sh1f40;
   localparam logic signed [15:0] RATIO_MIN = 16'shff9c;
   localparam logic signed [15:0] RATIO_MAX = 16'sh0064;
   localparam logic signed [15:0] SETPT_MIN = 16'sh03e8;
   localparam logic signed [15:0] SETPT_MAX = 16'sh1770;
   localparam logic signed [15:0] OFS_MIN   = 16'shfc19;
   localparam logic signed [15:0] OFS_MAX   = 16'sh03e7;
   localparam logic signed [15:0] PB_MIN    = 16'sh001e;
   localparam logic signed [15:0] PB_MAX    = 16'sh03de;
   localparam logic signed [15:0] ITIME_MIN = 16'sh0001;
   localparam logic signed [15:0] ITIME_MAX = 16'sh03e7;
   localparam logic signed [15:0] DTIME_MIN = 16'sh0000;
   localparam logic signed [15:0] DTIME_MAX = 16'sh2706;
   localparam logic signed [15:0] HEAT_MIN  = 16'sh0000;
   localparam logic signed [15:0] HEAT_MAX  = 16'sh0064;
   localparam logic signed [15:0] COOL_MIN  = 16'shff9c;
   localparam logic signed [15:0] COOL_MAX  = 16'sh0000;

   // reset values of the writable words
   localparam logic signed [15:0] SETPT_RST = 16'sh03e8;
   localparam logic signed [15:0] OFS_RST   = 16'sh0000;
   localparam logic signed [15:0] PB_RST    = 16'sh001e;
   localparam logic signed [15:0] ITIME_RST = 16'sh0001;
   localparam logic signed [15:0] DTIME_RST = 16'sh0000;
   localparam logic signed [15:0] HEAT_RST  = 16'sh0064;
   localparam logic signed [15:0] COOL_RST  = 16'shff9c;

   // negative answer fields
   localparam logic [7:0] FUNC_EXC_OFS = 8'h80;
   localparam logic [7:0] ERR_ADDRESS  = 8'h02;
   localparam logic [7:0] ERR_DATA     = 8'h03;

   // operation modes, low three bits of operation_select
   typedef enum logic [2:0] {
      MODE_PUMP_STOP = 3'h0,
      MODE_RUN       = 3'h1,
      MODE_AUTOTUNE  = 3'h2,
      MODE_LEARN     = 3'h3,
      MODE_EXT_TUNE  = 3'h4
   } tcr_mode_t;

   // answer sequencer, gray along idle -> answer
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ANSWER = 2'b01
   } tcr_state_t;

   // one decoded register access from the serial framer
   typedef struct packed {
      logic        write;
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] wdata;
   } tcr_req_t;

   // answer to one access
   typedef struct packed {
      logic        exc;
      logic [7:0]  func;
      logic [7:0]  code;
      logic [15:0] rdata;
   } tcr_rsp_t;

   // fault and warning inputs, one bit each
   typedef struct packed {
      logic limit_warning_lo;
      logic limit_warning_hi;
      logic low_level_fault;
      logic autotune_fault;
      logic outer_probe_open;
      logic inner_probe_open;
      logic low_flow_fault;
      logic drive_abnormal;
      logic thermostat_trip;
      logic inner_probe_undertemp;
      logic inner_probe_overtemp;
      logic dc_supply_fault;
      logic backup_store_fault;
      logic system_fault_two;
      logic system_fault_one;
   } tcr_faults_t;

   // measured values from the control core
   typedef struct packed {
      logic signed [15:0] int_probe;
      logic signed [15:0] ext_probe;
      logic signed [15:0] mean;
      logic signed [15:0] drive_pct;
   } tcr_meas_t;

   // settings handed to the control core
   typedef struct packed {
      tcr_mode_t          mode;
      logic signed [15:0] setpoint;
      logic signed [15:0] offset;
      logic signed [15:0] prop_band;
      logic signed [15:0] int_time;
      logic signed [15:0] der_time;
      logic signed [15:0] heat_cap;
      logic signed [15:0] cool_cap;
   } tcr_cfg_t;

endpackage : tcr_pkg

//--- src/tcr_regmap.sv
// holding-register bank of the temperature controller
// How it works
// RQ1: status bit 0 is 1 while running, 0 while stopped.
// RQ2: status bit 1 is 1 while any alarm is active.
// RQ3: status bit 2 is 1 while a warning is active; bits 3-15 zero.
// RQ4: fault word a bits 1,2,3 report system faults and backup fault.
// RQ5: fault word a bit 11 shows the dc supply fault.
// RQ6: fault word a bits 12,13 show inner probe over and under temperature.
// RQ7: fault word a bits 14,15 show thermostat trip and abnormal drive.
// RQ8: fault word b bits 0,1,2 show low flow and probe disconnections.
// RQ9: fault word b bits 3,4 show autotune and low level faults.
// RQ10: fault word b bits 12,13 show upper and lower limit warnings.
// RQ11: drive percentage is signed whole percent, -100 to +100.
// RQ12: setpoint, band and derivative time keep two decimal places.
// RQ13: temperatures are signed 16-bit in 0.01 degC, held within range.
// RQ14: unused bits read zero; the spare word takes no setting.
// RQ15: operation_select low three bits pick one of five modes.
// RQ16: setpoint writes beyond the range take the nearest limit.
// RQ17: an address outside the map answers with error code 02.
// RQ18: a negative answer carries function code plus 80h.
`timescale 1ns/1ps
module tcr_regmap
   import tcr_pkg::*;
(
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   // decoded access from the framer
   input  wire logic             req_valid_i,
   input  wire tcr_pkg::tcr_req_t req_i,
   // answer to the framer
   output logic                  rsp_valid_o,
   output tcr_pkg::tcr_rsp_t     rsp_o,
   // measurements from the control core
   input  wire tcr_pkg::tcr_meas_t meas_i,
   // fault pins, asynchronous
   input  wire tcr_pkg::tcr_faults_t fault_pins_i,
   // settings to the control core
   output tcr_pkg::tcr_cfg_t     cfg_o,
   output logic                  running_o
);

   import tcr_pkg::*;

   tcr_state_t         state_q;
   tcr_state_t         state_d;
   tcr_rsp_t           rsp_q;
   tcr_faults_t        faults;
   logic               take;
   logic               hit;
   logic               writable;
   logic               bad_data;
   logic               exc;
   logic [7:0]         code;
   logic [15:0]        rdata;
   logic               wr_en;
   logic [15:0]        cond_word;
   logic [15:0]        fault_a_word;
   logic [15:0]        fault_b_word;
   logic               any_alarm;
   logic               any_warn;
   tcr_mode_t          mode_q;
   logic signed [15:0] setpt_q;
   logic signed [15:0] ofs_q;
   logic signed [15:0] pb_q;
   logic signed [15:0] itime_q;
   logic signed [15:0] dtime_q;
   logic signed [15:0] heat_q;
   logic signed [15:0] cool_q;
   logic signed [15:0] int_probe_q;
   logic signed [15:0] ext_probe_q;
   logic signed [15:0] mean_q;
   logic signed [15:0] ratio_q;
   logic signed [15:0] int_probe_c;
   logic signed [15:0] ext_probe_c;
   logic signed [15:0] mean_c;
   logic signed [15:0] ratio_c;
   logic signed [15:0] setpt_c, ofs_c, pb_c, itime_c;
   logic signed [15:0] dtime_c, heat_c, cool_c;

   // fault pins come from other boards, so filter them into this clock
   tcr_sync3 #(
      .W($bits(tcr_faults_t))
   ) u_fault_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (fault_pins_i),
      .level_o   (faults)
   );

   // measured words saturate so a wild core value stays in range
   tcr_clamp u_int_probe (
      .val_i (meas_i.int_probe),
      .lo_i  (PROBE_MIN),
      .hi_i  (PROBE_MAX),
      .val_o (int_probe_c)
   );
   tcr_clamp u_ext_probe (
      .val_i (meas_i.ext_probe),
      .lo_i  (PROBE_MIN),
      .hi_i  (PROBE_MAX),
      .val_o (ext_probe_c)
   );
   tcr_clamp u_mean (
      .val_i (meas_i.mean),
      .lo_i  (PROBE_MIN),
      .hi_i  (PROBE_MAX),
      .val_o (mean_c)
   );
   tcr_clamp u_ratio (
      .val_i (meas_i.drive_pct),
      .lo_i  (RATIO_MIN),
      .hi_i  (RATIO_MAX),
      .val_o (ratio_c)
   );

   // written words saturate to their range
   tcr_clamp u_setpt (.val_i(req_i.wdata), .lo_i(SETPT_MIN), .hi_i(SETPT_MAX), .val_o(setpt_c));
   tcr_clamp u_ofs (.val_i(req_i.wdata), .lo_i(OFS_MIN), .hi_i(OFS_MAX), .val_o(ofs_c));
   tcr_clamp u_pb (.val_i(req_i.wdata), .lo_i(PB_MIN), .hi_i(PB_MAX), .val_o(pb_c));
   tcr_clamp u_itime (.val_i(req_i.wdata), .lo_i(ITIME_MIN), .hi_i(ITIME_MAX), .val_o(itime_c));
   tcr_clamp u_dtime (.val_i(req_i.wdata), .lo_i(DTIME_MIN), .hi_i(DTIME_MAX), .val_o(dtime_c));
   tcr_clamp u_heat (.val_i(req_i.wdata), .lo_i(HEAT_MIN), .hi_i(HEAT_MAX), .val_o(heat_c));
   tcr_clamp u_cool (.val_i(req_i.wdata), .lo_i(COOL_MIN), .hi_i(COOL_MAX), .val_o(cool_c));

   // measurement sampling, one cycle behind the core
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         int_probe_q <= '0;
         ext_probe_q <= '0;
         mean_q      <= '0;
         ratio_q     <= '0;
      end else begin
         int_probe_q <= int_probe_c;                           // [RQ13]
         ext_probe_q <= ext_probe_c;                           // [RQ13]
         mean_q      <= mean_c;                                // [RQ13]
         ratio_q     <= ratio_c;                               // [RQ11]
      end
   end

   // fault word a, gaps tied low
   always_comb begin
      fault_a_word                   = '0;                     // [RQ14]
      fault_a_word[FA_SYS_ONE_BIT]   = faults.system_fault_one;      // [RQ4]
      fault_a_word[FA_SYS_TWO_BIT]   = faults.system_fault_two;      // [RQ4]
      fault_a_word[FA_BACKUP_BIT]    = faults.backup_store_fault;    // [RQ4]
      fault_a_word[FA_DC_SUPPLY_BIT] = faults.dc_supply_fault;       // [RQ5]
      fault_a_word[FA_OVERTEMP_BIT]  = faults.inner_probe_overtemp;  // [RQ6]
      fault_a_word[FA_UNDERTEMP_BIT] = faults.inner_probe_undertemp; // [RQ6]
      fault_a_word[FA_THERMO_BIT]    = faults.thermostat_trip;       // [RQ7]
      fault_a_word[FA_DRIVE_BIT]     = faults.drive_abnormal;        // [RQ7]
   end

   // fault word b, gaps tied low
   always_comb begin
      fault_b_word                    = '0;                    // [RQ14]
      fault_b_word[FB_LOW_FLOW_BIT]   = faults.low_flow_fault;   // [RQ8]
      fault_b_word[FB_INNER_OPEN_BIT] = faults.inner_probe_open; // [RQ8]
      fault_b_word[FB_OUTER_OPEN_BIT] = faults.outer_probe_open; // [RQ8]
      fault_b_word[FB_AUTOTUNE_BIT]   = faults.autotune_fault;   // [RQ9]
      fault_b_word[FB_LOW_LEVEL_BIT]  = faults.low_level_fault;  // [RQ9]
      fault_b_word[FB_WARN_HI_BIT]    = faults.limit_warning_hi; // [RQ10]
      fault_b_word[FB_WARN_LO_BIT]    = faults.limit_warning_lo; // [RQ10]
   end

   // summary flags; warnings stay out of the alarm flag
   assign any_alarm = (|fault_a_word)
                    | faults.low_flow_fault | faults.inner_probe_open
                    | faults.outer_probe_open | faults.autotune_fault
                    | faults.low_level_fault;
   assign any_warn  = faults.limit_warning_hi | faults.limit_warning_lo;
   assign running_o = (mode_q != MODE_PUMP_STOP);

   // unit condition word
   always_comb begin
      cond_word                 = '0;                          // [RQ3] [RQ14]
      cond_word[COND_RUN_BIT]   = running_o;                   // [RQ1]
      cond_word[COND_ALARM_BIT] = any_alarm;                   // [RQ2]
      cond_word[COND_WARN_BIT]  = any_warn;                    // [RQ3]
   end

   // address decode and read data
   always_comb begin
      hit      = 1'b1;
      writable = 1'b0;
      rdata    = '0;
      if (req_i.addr == ADDR_INT_PROBE) begin
         rdata = int_probe_q;
      end else if (req_i.addr == ADDR_EXT_PROBE) begin
         rdata = ext_probe_q;
      end else if (req_i.addr == ADDR_MEAN) begin
         rdata = mean_q;
      end else if (req_i.addr == ADDR_CONDITION) begin
         rdata = cond_word;
      end else if (req_i.addr == ADDR_FAULT_A) begin
         rdata = fault_a_word;
      end else if (req_i.addr == ADDR_FAULT_B) begin
         rdata = fault_b_word;
      end else if (req_i.addr == ADDR_DRIVE_PCT) begin
         rdata = ratio_q;
      end else if (req_i.addr == ADDR_OP_SELECT) begin
         writable   = 1'b1;
         rdata[2:0] = mode_q;                                  // [RQ15]
      end else if (req_i.addr == ADDR_SETPOINT) begin
         writable = 1'b1;
         rdata    = setpt_q;
      end else if (req_i.addr == ADDR_OFFSET) begin
         writable = 1'b1;
         rdata    = ofs_q;
      end else if (req_i.addr == ADDR_PROP_BAND) begin
         writable = 1'b1;
         rdata    = pb_q;
      end else if (req_i.addr == ADDR_SPARE) begin
         writable = 1'b1;                                      // [RQ14]
      end else if (req_i.addr == ADDR_INT_TIME) begin
         writable = 1'b1;
         rdata    = itime_q;
      end else if (req_i.addr == ADDR_DER_TIME) begin
         writable = 1'b1;
         rdata    = dtime_q;
      end else if (req_i.addr == ADDR_HEAT_CAP) begin
         writable = 1'b1;
         rdata    = heat_q;
      end else if (req_i.addr == ADDR_COOL_CAP) begin
         writable = 1'b1;
         rdata    = cool_q;
      end else begin
         hit = 1'b0;                                           // [RQ17]
      end
   end

   // a mode code above the five defined is bad data
   assign bad_data = (req_i.addr == ADDR_OP_SELECT)
                   && ((req_i.wdata[15:3] != '0) || (req_i.wdata[2:0] > MODE_EXT_TUNE));

   // error choice: address first, then data
   always_comb begin
      exc  = 1'b0;
      code = '0;
      if (!hit || (req_i.write && !writable)) begin
         exc  = 1'b1;
         code = ERR_ADDRESS;                                   // [RQ17]
      end else if (req_i.write && bad_data) begin
         exc  = 1'b1;
         code = ERR_DATA;
      end
   end

   // every access is taken; the framer sends one at a time
   assign take  = req_valid_i;
   assign wr_en = take && req_i.write && !exc;

   // operation mode
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_q <= MODE_PUMP_STOP;
      end else if (wr_en && req_i.addr == ADDR_OP_SELECT) begin
         mode_q <= tcr_mode_t'(req_i.wdata[2:0]);              // [RQ15]
      end
   end

   // temperature words; lsb is 0.01 degC so two decimals are exact
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         setpt_q <= SETPT_RST;
         ofs_q   <= OFS_RST;
         pb_q    <= PB_RST;
      end else if (wr_en) begin
         if (req_i.addr == ADDR_SETPOINT) begin
            setpt_q <= setpt_c;                                // [RQ16] [RQ12] [RQ13]
         end
         if (req_i.addr == ADDR_OFFSET) begin
            ofs_q <= ofs_c;                                    // [RQ13]
         end
         if (req_i.addr == ADDR_PROP_BAND) begin
            pb_q <= pb_c;                                      // [RQ12]
         end
      end
   end

   // tuning times and drive caps
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         itime_q <= ITIME_RST;
         dtime_q <= DTIME_RST;
         heat_q  <= HEAT_RST;
         cool_q  <= COOL_RST;
      end else if (wr_en) begin
         if (req_i.addr == ADDR_INT_TIME) begin
            itime_q <= itime_c;
         end
         if (req_i.addr == ADDR_DER_TIME) begin
            dtime_q <= dtime_c;                                // [RQ12]
         end
         if (req_i.addr == ADDR_HEAT_CAP) begin
            heat_q <= heat_c;
         end
         if (req_i.addr == ADDR_COOL_CAP) begin
            cool_q <= cool_c;
         end
      end
   end

   // answer sequencer: one answer cycle per taken access
   always_comb begin
      case (state_q)
         ST_IDLE:   state_d = take ? ST_ANSWER : ST_IDLE;
         ST_ANSWER: state_d = take ? ST_ANSWER : ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // answer contents; a write returns the word as it stood before
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rsp_q <= '0;
      end else if (take) begin
         rsp_q.exc   <= exc;
         rsp_q.code  <= code;
         rsp_q.func  <= exc ? 8'(req_i.func + FUNC_EXC_OFS) : req_i.func;  // [RQ18]
         rsp_q.rdata <= exc ? '0 : rdata;
      end
   end

   assign rsp_valid_o = (state_q == ST_ANSWER);
   assign rsp_o       = rsp_q;

   // settings out to the control core
   assign cfg_o.mode      = mode_q;
   assign cfg_o.setpoint  = setpt_q;
   assign cfg_o.offset    = ofs_q;
   assign cfg_o.prop_band = pb_q;
   assign cfg_o.int_time  = itime_q;
   assign cfg_o.der_time  = dtime_q;
   assign cfg_o.heat_cap  = heat_q;
   assign cfg_o.cool_cap  = cool_q;

endmodule : tcr_regmap

//--- src/tcr_sync3.sv
// three-stage synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module tcr_sync3 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   // asynchronous levels in, filtered levels out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // stage one feeds only stage two
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // per bit, take the value only when the last two stages agree
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         level_o <= '0;
      end else begin
         level_o <= (s2_q & s3_q) | (level_o & (s2_q | s3_q));
      end
   end

endmodule : tcr_sync3

//--- test/tcr_host_model.sv
// host model: one register access at a time
`timescale 1ns/1ps
module tcr_host_model (
   // clock
   input  wire logic              mclk_i,
   // access out, answer in
   output logic                   req_valid_o,
   output tcr_pkg::tcr_req_t      req_o,
   input  wire logic              rsp_valid_i,
   input  wire tcr_pkg::tcr_rsp_t rsp_i
);
   import tcr_pkg::*;
   logic [33:0] ans;
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // one word access; fields go to junk once released
   task automatic access(input logic w, input logic [7:0] f, input logic [15:0] a,
                         input logic [15:0] d);
      @(negedge mclk_i);
      req_valid_o = 1'b1;
      req_o = '{write: w, func: f, addr: a, wdata: d};
      @(negedge mclk_i);
      req_valid_o = 1'b0;
      req_o = ~req_o;
      ans = {rsp_valid_i, rsp_i};
   endtask : access
endmodule : tcr_host_model

//--- test/tcr_regmap_sva.sv
// checker for the register bank ports
`timescale 1ns/1ps
module tcr_regmap_sva (
   // clock and reset
   input wire logic                mclk_i,
   input wire logic                sys_rst_i,
   // access and answer
   input wire logic                req_valid_i,
   input wire tcr_pkg::tcr_req_t   req_i,
   input wire logic                rsp_valid_o,
   input wire tcr_pkg::tcr_rsp_t   rsp_o,
   // side signals
   input wire tcr_pkg::tcr_meas_t  meas_i,
   input wire tcr_pkg::tcr_faults_t fault_pins_i,
   input wire tcr_pkg::tcr_cfg_t   cfg_o,
   input wire logic                running_o
);
   import tcr_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   logic mapped, rd;
   // mapped addresses
   assign mapped = req_i.addr inside {[16'h0040:16'h0046], [16'h0050:16'h0058]};
   assign rd = req_valid_i && !req_i.write;
   property p_answer; req_valid_i |=> rsp_valid_o; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_quiet; !req_valid_i |=> !rsp_valid_o; endproperty
   a_quiet: assert property (p_quiet) else $error("spurious answer");
   property p_run;
      req_valid_i && req_i.write && req_i.addr == ADDR_OP_SELECT && req_i.wdata <= 16'h0004
      |=> running_o == ($past(req_i.wdata) != 16'h0000) && cfg_o.mode == $past(req_i.wdata[2:0]);
   endproperty
   a_run: assert property (p_run) else $error("mode write");
   property p_cond;
      rd && req_i.addr == ADDR_CONDITION
      |=> rsp_o.rdata[15:3] == 13'h0 && rsp_o.rdata[0] == $past(running_o);
   endproperty
   a_cond: assert property (p_cond) else $error("status word");
   property p_fa;
      rd && req_i.addr == ADDR_FAULT_A |=> !rsp_o.rdata[0] && rsp_o.rdata[10:4] == 7'h0;
   endproperty
   a_fa: assert property (p_fa) else $error("fault word a");
   property p_fb;
      rd && req_i.addr == ADDR_FAULT_B |=> rsp_o.rdata[11:5] == 7'h0 && rsp_o.rdata[15:14] == 2'h0;
   endproperty
   a_fb: assert property (p_fb) else $error("fault word b");
   property p_exc;
      req_valid_i && !mapped |=> rsp_o.exc && rsp_o.code == ERR_ADDRESS
         && rsp_o.func == 8'($past(req_i.func) + FUNC_EXC_OFS);
   endproperty
   a_exc: assert property (p_exc) else $error("negative answer");
   property p_setpt; cfg_o.setpoint >= SETPT_MIN && cfg_o.setpoint <= SETPT_MAX; endproperty
   a_setpt: assert property (p_setpt) else $error("setpoint range");
   property p_ratio;
      rd && req_i.addr == ADDR_DRIVE_PCT
      |=> $signed(rsp_o.rdata) >= RATIO_MIN && $signed(rsp_o.rdata) <= RATIO_MAX;
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio range");
   property p_mode; cfg_o.mode <= MODE_EXT_TUNE; endproperty
   a_mode: assert property (p_mode) else $error("mode code");
   c_exc: cover property (req_valid_i && !mapped);
   c_alarm: cover property (rsp_valid_o && rsp_o.rdata[1] && rsp_o.rdata[0]);
   c_run: cover property ($rose(running_o));
endmodule : tcr_regmap_sva
bind tcr_regmap tcr_regmap_sva tcr_regmap_sva_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .req_valid_i(req_valid_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
   .meas_i(meas_i), .fault_pins_i(fault_pins_i), .cfg_o(cfg_o), .running_o(running_o));

//--- test/tcr_regmap_tb_top.sv
// self-checking bench of the register bank
`timescale 1ns/1ps
module tcr_regmap_tb_top;
   import tcr_pkg::*;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        req_valid_i, rsp_valid_o, running_o;
   tcr_req_t    req_i;
   tcr_rsp_t    rsp_o;
   tcr_meas_t   meas_i = '0;
   tcr_faults_t fault_pins_i = '0;
   tcr_cfg_t    cfg_o;
   int          mismatches = 0, n_checks = 0, cyc = 0;
   logic [15:0] v, s, f;
   logic [15:0] rst_tab [9] = '{16'h0, SETPT_RST, OFS_RST, PB_RST, 16'h0, ITIME_RST,
                                DTIME_RST, HEAT_RST, COOL_RST};
   logic [15:0] bad [4] = '{16'h0047, 16'h004f, 16'h0059, 16'h0100};
   always #10 mclk_i = ~mclk_i;
   tcr_regmap tcr_regmap_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .meas_i(meas_i),
      .fault_pins_i(fault_pins_i), .cfg_o(cfg_o), .running_o(running_o));
   tcr_host_model tcr_host_model_i (.mclk_i(mclk_i), .req_valid_o(req_valid_i), .req_o(req_i),
      .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o));
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   function automatic logic [15:0] clamp(input logic signed [15:0] x, lo, hi);
      return (x < lo) ? lo : ((x > hi) ? hi : x);
   endfunction : clamp
   // plain read of one word
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      tcr_host_model_i.access(1'b0, 8'h03, a, 16'($urandom));
      check(tcr_host_model_i.ans, {2'b10, 8'h03, 8'h00, exp});
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      tcr_host_model_i.access(1'b1, 8'h06, a, d);
      check(tcr_host_model_i.ans[33:16], {2'b10, 8'h06, 8'h00});
   endtask : wr
   // hang guard, the run needs about 540 cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(32'h8ac7));
      repeat (5) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      for (int i = 0; i < 9; i++) rd(16'h0050 + 16'(i), rst_tab[i]);
      for (int m = 0; m < 5; m++) begin
         wr(ADDR_OP_SELECT, 16'(m));
         check(running_o, m != 0);
         rd(ADDR_CONDITION, {15'h0, m != 0});
         rd(ADDR_OP_SELECT, 16'(m));
      end
      tcr_host_model_i.access(1'b1, 8'h06, ADDR_OP_SELECT, 16'h0005);
      check(tcr_host_model_i.ans, {2'b11, 8'h06 + FUNC_EXC_OFS, ERR_DATA, 16'h0});
      for (int i = 0; i < 5; i++) begin
         f = 16'($urandom) & 16'h007f;
         tcr_host_model_i.access(i == 4, f[7:0], (i == 4) ? ADDR_CONDITION : bad[i], 16'h0);
         check(tcr_host_model_i.ans, {2'b11, f[7:0] + FUNC_EXC_OFS, ERR_ADDRESS, 16'h0});
      end
      for (int i = 0; i < 12; i++) begin
         v = (i < 4) ? bad[i] * 16'h0100 - 16'h3e87 : 16'($urandom);
         wr(ADDR_SETPOINT, v);
         rd(ADDR_SETPOINT, clamp(v, SETPT_MIN, SETPT_MAX));
         wr(ADDR_OFFSET, v);
         rd(ADDR_OFFSET, clamp(v, OFS_MIN, OFS_MAX));
      end
      for (int i = 0; i < 8; i++) begin
         @(negedge mclk_i);
         meas_i = {$urandom, $urandom >> (i * 4)};
         rd(ADDR_DRIVE_PCT, clamp(meas_i.drive_pct, RATIO_MIN, RATIO_MAX));
         rd(ADDR_INT_PROBE, clamp(meas_i.int_probe, PROBE_MIN, PROBE_MAX));
         rd(ADDR_EXT_PROBE, clamp(meas_i.ext_probe, PROBE_MIN, PROBE_MAX));
         rd(ADDR_MEAN, clamp(meas_i.mean, PROBE_MIN, PROBE_MAX));
      end
      wr(ADDR_OP_SELECT, 16'h0001);
      for (int i = 0; i < 20; i++) begin
         @(negedge mclk_i);
         fault_pins_i = (i < 15) ? 15'h1 << i : 15'($urandom);
         s = 16'(fault_pins_i);
         repeat (8) @(negedge mclk_i);
         rd(ADDR_FAULT_A, {s[7:3], 7'h0, s[2:0], 1'b0});
         rd(ADDR_FAULT_B, {2'h0, s[14:13], 7'h0, s[12:8]});
         rd(ADDR_CONDITION, {13'h0, |s[14:13], |s[12:0], 1'b1});
      end
      complete_run();
   end
endmodule : tcr_regmap_tb_top
